/* src/uis_flag.sv */
// module: one sticky status flag, hardware set wins over software clear
`timescale 1ns/1ps
module uis_flag
  import uis_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic setEvt,
  input wire logic clrEvt,
  output logic q
);

  // ==========================================================================
  // flag storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= RESET_VALUE;
    end else if (setEvt) begin
      q <= 1'b1;
    end else if (clrEvt) begin
      q <= 1'b0;
    end
  end

endmodule : uis_flag

/* src/uis_pkg.sv */
// package: register map, field layout and carrier types of the usb interrupt status 0 block
package uis_pkg;

  // ==========================================================================
  // bus geometry
  localparam int UIS_ADDR_W = 16;
  localparam int UIS_DATA_W = 8;

  // ==========================================================================
  // register offsets
  localparam logic [15:0] UIS_ADDR_STATUS0 = 16'hFF27;
  localparam logic [15:0] UIS_ADDR_CLEAR0 = 16'hFF30;
  localparam logic [15:0] UIS_ADDR_ENABLE0 = 16'hFF31;
  localparam logic [15:0] UIS_ADDR_SET_TARGET = 16'hFF32;
  localparam logic [15:0] UIS_ADDR_CLEAR_TARGET = 16'hFF33;

  // ==========================================================================
  // status field positions
  localparam int UIS_BIT_BUS_RESET = 7;
  localparam int UIS_BIT_RESUME_SUSPEND = 6;
  localparam int UIS_BIT_SET_REQUEST = 2;
  localparam int UIS_BIT_CLEAR_REQUEST = 1;
  localparam int UIS_BIT_ENDPOINT_STALL = 0;

  // ==========================================================================
  // reset values and masks
  localparam logic [7:0] UIS_STATUS_RESET = 8'h00;
  localparam logic [7:0] UIS_IMPL_MASK = 8'hC7;
  localparam logic [7:0] UIS_ENABLE_RESET = 8'hC7;
  localparam logic [7:0] UIS_RDATA_IDLE = 8'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uis_bus_s;

  typedef struct packed {
    logic busReset;
    logic suspendEnter;
    logic resumeDetect;
    logic setAccepted;
    logic setIsEndpoint;
    logic clearAccepted;
    logic statusDone;
    logic setupToken;
    logic endpointStall;
    logic fwStall;
  } uis_evt_s;

endpackage : uis_pkg

/* src/uis_req_tracker.sv */
// module: holds an accepted standard request until its status stage completes
`timescale 1ns/1ps
module uis_req_tracker
  import uis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic accepted,
  input wire logic tagIn,
  input wire logic statusDone,
  input wire logic setupToken,
  output logic fire,
  output logic tagOut
);

  logic pending;

  // ==========================================================================
  // pending request; a fresh setup token drops an unfinished one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (accepted) begin
      pending <= 1'b1;
    end else if (statusDone || setupToken) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tagOut <= 1'b0;
    end else if (accepted) begin
      tagOut <= tagIn;
    end
  end

  // pulse only once the status stage is over, never at setup time
  always_comb begin
    fire = pending && statusDone && !accepted;
  end

endmodule : uis_req_tracker

/* src/uis_top.sv */
// module: usb interrupt status 0 register with clear, enable and interrupt output
`timescale 1ns/1ps
module uis_top
  import uis_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire uis_bus_s bus,
  output logic [7:0] busRdata,
  input wire uis_evt_s evt,
  input wire logic [7:0] setTarget,
  input wire logic [7:0] clearTarget,
  output logic usbFunctionIrq
);

  // ==========================================================================
  // declarations
  logic [7:0] status;
  logic [7:0] enable;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic setFire;
  logic setTag;
  logic clrFire;
  logic clearWrite;
  logic enableWrite;
  logic [7:0] next_rdata;
  logic next_irq;

  // ==========================================================================
  // request trackers
  uis_req_tracker u_set_req (
    .clk_sys(clk_sys),
    .rst(rst),
    .accepted(evt.setAccepted),
    .tagIn(evt.setIsEndpoint),
    .statusDone(evt.statusDone),
    .setupToken(evt.setupToken),
    .fire(setFire),
    .tagOut(setTag)
  );

  uis_req_tracker u_clr_req (
    .clk_sys(clk_sys),
    .rst(rst),
    .accepted(evt.clearAccepted),
    .tagIn(1'b0),
    .statusDone(evt.statusDone),
    .setupToken(evt.setupToken),
    .fire(clrFire),
    .tagOut()
  );

  // ==========================================================================
  // event and clear vectors
  always_comb begin
    setVec = 8'h00;
    setVec[UIS_BIT_BUS_RESET] = evt.busReset;
    setVec[UIS_BIT_RESUME_SUSPEND] = evt.suspendEnter || evt.resumeDetect;
    setVec[UIS_BIT_SET_REQUEST] = setFire;
    setVec[UIS_BIT_CLEAR_REQUEST] = clrFire;
    // no later standard request clears the stall bit
    setVec[UIS_BIT_ENDPOINT_STALL] = evt.endpointStall || evt.fwStall || (setFire && setTag);
  end

  always_comb begin
    clearWrite = bus.wr && (bus.addr == UIS_ADDR_CLEAR0);
    enableWrite = bus.wr && (bus.addr == UIS_ADDR_ENABLE0);
    // a zero written clears; ones leave the bit alone
    clrVec = clearWrite ? ~bus.wdata : 8'h00;
  end

  // ==========================================================================
  // status flags; unimplemented positions stay at zero
  for (genvar i = 0; i < 8; i++) begin : g_flag
    if (UIS_IMPL_MASK[i]) begin : g_impl
      uis_flag #(
        .RESET_VALUE(UIS_STATUS_RESET[i])
      ) u_flag (
        .clk_sys(clk_sys),
        .rst(rst),
        .setEvt(setVec[i]),
        .clrEvt(clrVec[i]),
        .q(status[i])
      );
    end else begin : g_zero
      assign status[i] = 1'b0;
    end
  end

  // ==========================================================================
  // enable register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable <= UIS_ENABLE_RESET;
    end else if (enableWrite) begin
      enable <= bus.wdata & UIS_IMPL_MASK;
    end
  end

  // ==========================================================================
  // interrupt line, one cycle behind the status flags
  always_comb begin
    next_irq = |(status & enable);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usbFunctionIrq <= 1'b0;
    end else begin
      usbFunctionIrq <= next_irq;
    end
  end

  // ==========================================================================
  // read path; reads have no side effect on any flag
  always_comb begin
    next_rdata = UIS_RDATA_IDLE;
    if (bus.rd) begin
      case (bus.addr)
        UIS_ADDR_STATUS0: next_rdata = status;
        UIS_ADDR_ENABLE0: next_rdata = enable;
        UIS_ADDR_SET_TARGET: next_rdata = setTarget;
        UIS_ADDR_CLEAR_TARGET: next_rdata = clearTarget;
        default: next_rdata = UIS_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busRdata <= UIS_RDATA_IDLE;
    end else begin
      busRdata <= next_rdata;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_status_read_only: assert property (
    (bus.wr && bus.addr == UIS_ADDR_STATUS0 && setVec == 8'h00)
    |=> (status == $past(status))
  ) else $error("status changed on a write to its own address");

  a_irq_follows_status: assert property (
    (|(status & enable)) |=> usbFunctionIrq
  ) else $error("interrupt not raised for an enabled status bit");

  a_irq_quiet: assert property (
    !(|(status & enable)) |=> !usbFunctionIrq
  ) else $error("interrupt high with no enabled status bit");

  a_irq_on_change: assert property (
    ($rose(status[UIS_BIT_BUS_RESET]) && enable[UIS_BIT_BUS_RESET]) |=> usbFunctionIrq
  ) else $error("bus reset flag rose without interrupt");

  a_clear_zero_bits: assert property (
    (clearWrite && setVec == 8'h00)
    |=> ((status & ~$past(bus.wdata)) == 8'h00)
  ) else $error("clear write left a status bit set");

  a_clear_ones_keep: assert property (
    (clearWrite && bus.wdata == 8'hFF) |=> ((status & $past(status)) == $past(status))
  ) else $error("clear write of ones dropped a status bit");

  a_set_wins: assert property (
    (setVec != 8'h00) |=> ((status & $past(setVec)) == $past(setVec))
  ) else $error("hardware event lost against a clear");

  a_bus_reset_sets: assert property (
    evt.busReset |=> status[UIS_BIT_BUS_RESET]
  ) else $error("bus reset did not set bit 7");

  a_suspend_sets: assert property (
    (evt.suspendEnter || evt.resumeDetect) |=> status[UIS_BIT_RESUME_SUSPEND]
  ) else $error("suspend or resume did not set bit 6");

  a_set_after_status: assert property (
    (u_set_req.pending && evt.statusDone && !evt.setAccepted)
    |=> status[UIS_BIT_SET_REQUEST]
  ) else $error("set request bit missing after status stage");

  a_set_not_early: assert property (
    $rose(status[UIS_BIT_SET_REQUEST]) |-> $past(evt.statusDone)
  ) else $error("set request bit rose before the status stage");

  a_set_tgt_read: assert property (
    (bus.rd && bus.addr == UIS_ADDR_SET_TARGET && status[UIS_BIT_SET_REQUEST])
    |=> status[UIS_BIT_SET_REQUEST]
  ) else $error("set target read cleared the set request bit");

  a_clear_not_early: assert property (
    $rose(status[UIS_BIT_CLEAR_REQUEST]) |-> $past(evt.statusDone)
  ) else $error("clear request bit rose before the status stage");

  a_clr_tgt_read: assert property (
    (bus.rd && bus.addr == UIS_ADDR_CLEAR_TARGET && status[UIS_BIT_CLEAR_REQUEST])
    |=> status[UIS_BIT_CLEAR_REQUEST]
  ) else $error("clear target read cleared the clear request bit");

  a_ep_setfeature_stall: assert property (
    (setFire && setTag) |=> (status[UIS_BIT_ENDPOINT_STALL] && status[UIS_BIT_SET_REQUEST])
  ) else $error("endpoint set feature did not set the stall bit");

  a_stall_sticky: assert property (
    (status[UIS_BIT_ENDPOINT_STALL] && !clrVec[UIS_BIT_ENDPOINT_STALL])
    |=> status[UIS_BIT_ENDPOINT_STALL]
  ) else $error("stall bit cleared without a clear write");

  a_fw_stall_sets: assert property (
    evt.fwStall |=> status[UIS_BIT_ENDPOINT_STALL]
  ) else $error("firmware stall did not set bit 0");

  a_reserved_zero: assert property (
    status[5:3] == 3'h0
  ) else $error("reserved status bits not zero");

  a_status_readback: assert property (
    (bus.rd && bus.addr == UIS_ADDR_STATUS0) |=> (busRdata == $past(status))
  ) else $error("status read returned wrong data");

  a_rdata_idle: assert property (
    !bus.rd |=> (busRdata == UIS_RDATA_IDLE)
  ) else $error("read data not idle outside a read answer");

  // ==========================================================================
  // assertion helpers; clear register is write only, so it counts as unmapped here
  logic rdMapped;

  always_comb begin
    rdMapped = (bus.addr == UIS_ADDR_STATUS0) || (bus.addr == UIS_ADDR_ENABLE0) ||
      (bus.addr == UIS_ADDR_SET_TARGET) || (bus.addr == UIS_ADDR_CLEAR_TARGET);
  end

  a_clear_after_status: assert property (
    (u_clr_req.pending && evt.statusDone && !evt.clearAccepted)
    |=> status[UIS_BIT_CLEAR_REQUEST]
  ) else $error("clear request bit missing after status stage");

  a_set_needs_request: assert property (
    $rose(status[UIS_BIT_SET_REQUEST]) |-> $past(u_set_req.pending)
  ) else $error("set request bit rose with no request pending");

  a_clear_needs_request: assert property (
    $rose(status[UIS_BIT_CLEAR_REQUEST]) |-> $past(u_clr_req.pending)
  ) else $error("clear request bit rose with no request pending");

  a_setup_drops_set: assert property (
    (evt.setupToken && !evt.setAccepted && !evt.statusDone) |=> !u_set_req.pending
  ) else $error("setup token left an old set request pending");

  a_setup_drops_clear: assert property (
    (evt.setupToken && !evt.clearAccepted && !evt.statusDone) |=> !u_clr_req.pending
  ) else $error("setup token left an old clear request pending");

  a_stall_event_sets: assert property (
    evt.endpointStall |=> status[UIS_BIT_ENDPOINT_STALL]
  ) else $error("endpoint stall did not set bit 0");

  a_stall_beats_clear: assert property (
    (evt.endpointStall && clrVec[UIS_BIT_ENDPOINT_STALL])
    |=> status[UIS_BIT_ENDPOINT_STALL]
  ) else $error("stall lost against a clear in the same cycle");

  a_stall_needs_event: assert property (
    $rose(status[UIS_BIT_ENDPOINT_STALL])
    |-> $past(evt.endpointStall || evt.fwStall || (setFire && setTag))
  ) else $error("stall bit rose with no stall event");

  a_resume_sets: assert property (
    evt.resumeDetect |=> status[UIS_BIT_RESUME_SUSPEND]
  ) else $error("resume did not set bit 6");

  a_status_hold: assert property (
    (setVec == 8'h00 && clrVec == 8'h00)
    |=> (status == $past(status))
  ) else $error("status changed with no event and no clear");

  a_enable_write: assert property (
    enableWrite
    |=> (enable == ($past(bus.wdata) & UIS_IMPL_MASK))
  ) else $error("enable register took the wrong value");

  a_enable_reserved: assert property (
    (enable & ~UIS_IMPL_MASK) == 8'h00
  ) else $error("reserved enable bits not zero");

  a_enable_readback: assert property (
    (bus.rd && bus.addr == UIS_ADDR_ENABLE0)
    |=> (busRdata == $past(enable))
  ) else $error("enable read returned wrong data");

  a_set_tgt_readback: assert property (
    (bus.rd && bus.addr == UIS_ADDR_SET_TARGET)
    |=> (busRdata == $past(setTarget))
  ) else $error("set target read returned wrong data");

  a_clr_tgt_readback: assert property (
    (bus.rd && bus.addr == UIS_ADDR_CLEAR_TARGET)
    |=> (busRdata == $past(clearTarget))
  ) else $error("clear target read returned wrong data");

  a_unmapped_read: assert property (
    (bus.rd && !rdMapped)
    |=> (busRdata == UIS_RDATA_IDLE)
  ) else $error("unmapped or write only read returned data");

  a_irq_clear_drop: assert property (
    (clearWrite && bus.wdata == 8'h00 && setVec == 8'h00)
    |-> ##2 !usbFunctionIrq
  ) else $error("interrupt stayed high after a full clear");

  // ==========================================================================
  // covers
  c_irq_raised: cover property ($rose(usbFunctionIrq));

  c_set_request_done: cover property (setFire ##1 status[UIS_BIT_SET_REQUEST]);

  c_reset_then_clear: cover property (
    status[UIS_BIT_BUS_RESET] ##1 clearWrite ##1 !status[UIS_BIT_BUS_RESET]
  );

  c_ep_stall_by_set: cover property (setFire && setTag);

  c_clear_request_done: cover property (clrFire ##1 status[UIS_BIT_CLEAR_REQUEST]);

endmodule : uis_top

/* test/test_uis_top.sv */
// testbench: self-checking bench of the usb interrupt status 0 block
`timescale 1ns/1ps
module test_uis_top;
  import uis_pkg::*;
  logic clk_sys;
  logic rst;
  uis_bus_s bus;
  logic [7:0] busRdata;
  uis_evt_s evt;
  logic [7:0] setTarget;
  logic [7:0] clearTarget;
  logic usbFunctionIrq;
  int numErrors;
  int samplesChecked;
  logic [7:0] expQ[$];
  logic rdPend;

  uis_top dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(bus),
    .busRdata(busRdata),
    .evt(evt),
    .setTarget(setTarget),
    .clearTarget(clearTarget),
    .usbFunctionIrq(usbFunctionIrq)
  );

  always #20 clk_sys = ~clk_sys;

  // ==========================================================================
  // checking and closing
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finalReport;
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finalReport

  // ==========================================================================
  // bus and event drivers
  task automatic wrReg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    bus.addr <= addr;
    bus.wdata <= data;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wrReg

  // expectation is queued here, compared by the read monitor
  task automatic rdReg(input logic [15:0] addr, input logic [7:0] exp);
    @(posedge clk_sys);
    bus.addr <= addr;
    bus.rd <= 1'b1;
    expQ.push_back(exp);
    @(posedge clk_sys);
    bus.rd <= 1'b0;
  endtask : rdReg

  task automatic pulse(input logic [9:0] v);
    @(posedge clk_sys);
    evt <= uis_evt_s'(v);
    @(posedge clk_sys);
    evt <= '0;
  endtask : pulse

  // bounded wait; a level never reached ends the run
  task automatic waitIrq(input logic exp);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (usbFunctionIrq === exp) break;
    end
    check("usbFunctionIrq", {7'h00, usbFunctionIrq}, {7'h00, exp});
    if (usbFunctionIrq !== exp) finalReport();
  endtask : waitIrq

  // ==========================================================================
  // read monitor: data stands only in the cycle after the strobe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) rdPend <= 1'b0;
    else rdPend <= bus.rd;
  end

  always @(negedge clk_sys) begin
    if (rdPend && expQ.size() > 0) check("busRdata", busRdata, expQ.pop_front());
  end

  // ==========================================================================
  // main sequence
  initial begin
    int evBit[5] = '{9, 8, 7, 1, 0};
    logic [7:0] evExp[5] = '{8'h80, 8'h40, 8'h40, 8'h01, 8'h01};
    logic [7:0] m;
    logic [7:0] st;
    logic [7:0] ct;
    int r;
    clk_sys = 1'b0;
    rst = 1'b1;
    bus = '0;
    evt = '0;
    setTarget = 8'h00;
    clearTarget = 8'h00;
    r = $urandom(95);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rdReg(UIS_ADDR_STATUS0, 8'h00);
    rdReg(UIS_ADDR_ENABLE0, 8'hC7);
    wrReg(UIS_ADDR_STATUS0, 8'hFF);
    rdReg(UIS_ADDR_STATUS0, 8'h00);
    rdReg(16'hFF40, 8'h00);
    // each of the five direct event sources, then cleared by a zero in its clear bit
    for (int i = 0; i < 5; i++) begin
      pulse(10'h001 << evBit[i]);
      rdReg(UIS_ADDR_STATUS0, evExp[i]);
      waitIrq(1'b1);
      wrReg(UIS_ADDR_CLEAR0, ~evExp[i]);
      rdReg(UIS_ADDR_STATUS0, 8'h00);
      waitIrq(1'b0);
    end
    st = 8'($urandom);
    ct = 8'($urandom);
    @(posedge clk_sys);
    setTarget <= st;
    clearTarget <= ct;
    // endpoint set feature: nothing until the status stage
    pulse(10'h060);
    repeat (2) @(posedge clk_sys);
    rdReg(UIS_ADDR_STATUS0, 8'h00);
    pulse(10'h008);
    rdReg(UIS_ADDR_STATUS0, 8'h05);
    rdReg(UIS_ADDR_SET_TARGET, st);
    rdReg(UIS_ADDR_STATUS0, 8'h05);
    wrReg(UIS_ADDR_CLEAR0, 8'hFA);
    pulse(10'h010);
    pulse(10'h008);
    rdReg(UIS_ADDR_STATUS0, 8'h02);
    rdReg(UIS_ADDR_CLEAR_TARGET, ct);
    rdReg(UIS_ADDR_STATUS0, 8'h02);
    wrReg(UIS_ADDR_CLEAR0, 8'hFD);
    // plain set configuration, then one dropped by a new setup token
    pulse(10'h040);
    pulse(10'h008);
    rdReg(UIS_ADDR_STATUS0, 8'h04);
    wrReg(UIS_ADDR_CLEAR0, 8'h00);
    pulse(10'h040);
    pulse(10'h004);
    pulse(10'h008);
    rdReg(UIS_ADDR_STATUS0, 8'h00);
    wrReg(UIS_ADDR_CLEAR0, 8'h00);
    // masked source keeps the line low until enabled
    wrReg(UIS_ADDR_ENABLE0, 8'h00);
    rdReg(UIS_ADDR_ENABLE0, 8'h00);
    pulse(10'h200);
    repeat (3) @(negedge clk_sys);
    check("usbFunctionIrq", {7'h00, usbFunctionIrq}, 8'h00);
    wrReg(UIS_ADDR_ENABLE0, 8'hFF);
    rdReg(UIS_ADDR_ENABLE0, 8'hC7);
    waitIrq(1'b1);
    wrReg(UIS_ADDR_CLEAR0, 8'h00);
    // random clear masks over three set bits
    for (int k = 0; k < 6; k++) begin
      pulse(10'h200);
      pulse(10'h100);
      pulse(10'h002);
      m = 8'($urandom);
      wrReg(UIS_ADDR_CLEAR0, m);
      rdReg(UIS_ADDR_STATUS0, 8'hC1 & m);
      wrReg(UIS_ADDR_CLEAR0, 8'h00);
      rdReg(UIS_ADDR_STATUS0, 8'h00);
    end
    repeat (3) @(posedge clk_sys);
    check("pendingReads", 8'(expQ.size()), 8'h00);
    finalReport();
  end
endmodule : test_uis_top
